// *** design/teh_pkg.sv ***
package teh_pkg;
  // register word offsets (byte addresses)
  localparam logic [7:0] TEH_OFF_CTRL1 = 8'h00;  // timer_control_one
  localparam logic [7:0] TEH_OFF_CTRL2 = 8'h04;  // preload and hall routing
  localparam logic [7:0] TEH_OFF_SMCTRL = 8'h08;  // slave mode and trigger select
  localparam logic [7:0] TEH_OFF_STS = 8'h10;  // sticky event flags
  localparam logic [7:0] TEH_OFF_CCMOD = 8'h18;  // channel source selects
  localparam logic [7:0] TEH_OFF_CCEN = 8'h20;  // channel polarities
  localparam logic [7:0] TEH_OFF_CNT = 8'h24;  // counter value
  localparam logic [7:0] TEH_OFF_AR = 8'h2C;  // auto_reload_value
  localparam logic [7:0] TEH_OFF_CCDAT1 = 8'h34;  // channel 1 capture
  localparam logic [7:0] TEH_OFF_CCDAT2 = 8'h38;  // channel 2 pulse compare
  localparam logic [7:0] TEH_OFF_OUTCTL = 8'h3C;  // preload / active output bits

  // timer_control_one fields
  localparam int TEH_B_RUN = 0;  // counter_run
  localparam int TEH_B_UPDIS = 1;  // update event disable
  localparam int TEH_B_UPRS = 2;  // update only on wrap
  localparam int TEH_B_DIR = 4;  // count_direction_flag, 1 = down
  // control two fields
  localparam int TEH_B_CCR_PRELOAD_CTL = 0;  // ccr_preload_ctl
  localparam int TEH_B_CCR_UPDATE_SELECT = 2;  // ccr_update_select
  localparam int TEH_B_HALL = 7;  // xor of three channels onto input_a
  // slave control fields
  localparam int TEH_B_SLAVE_MODE_SELECT = 0;  // slave_mode_select [2:0]
  localparam int TEH_B_TRIGGER_SELECT = 4;  // trigger_select [2:0]
  // status fields
  localparam int TEH_B_UDF = 0;  // update flag
  localparam int TEH_B_CC1F = 1;  // channel 1 capture flag
  localparam int TEH_B_COMF = 5;  // commutation flag
  localparam int TEH_B_TRGF = 6;  // trigger_flag
  // channel mode fields
  localparam int TEH_B_CHAN1_SOURCE_SELECT = 0;  // chan1_source_select [1:0]
  localparam int TEH_B_CHAN2_SOURCE_SELECT = 8;  // chan2_source_select [1:0]
  // polarity fields
  localparam int TEH_B_CHAN1_POLARITY = 1;  // chan1_polarity
  localparam int TEH_B_CHAN2_POLARITY = 5;  // chan2_polarity

  // reset values
  localparam logic [31:0] TEH_RST_WORD = 32'h0000_0000;
  localparam logic [15:0] TEH_RST_AR = 16'hFFFF;

  // slave_mode_select codes
  localparam logic [2:0] TEH_SM_OFF = 3'h0;
  localparam logic [2:0] TEH_SM_ENC_A = 3'h1;
  localparam logic [2:0] TEH_SM_ENC_B = 3'h2;
  localparam logic [2:0] TEH_SM_ENC_AB = 3'h3;
  localparam logic [2:0] TEH_SM_RESET = 3'h4;
  // trigger_select codes above the internal lines
  localparam logic [2:0] TEH_TS_AEDGE = 3'h4;  // input_a_edge_detect
  localparam logic [2:0] TEH_TS_FA = 3'h5;
  localparam logic [2:0] TEH_TS_FB = 3'h6;
  // channel source codes
  localparam logic [1:0] TEH_CS_OUT = 2'h0;
  localparam logic [1:0] TEH_CS_DIRECT = 2'h1;
  localparam logic [1:0] TEH_CS_TRC = 2'h3;

  // half-word write lane masks
  localparam logic [31:0] TEH_MASK_LO = 32'h0000_FFFF;
  localparam logic [31:0] TEH_MASK_HI = 32'hFFFF_0000;
  localparam logic [31:0] TEH_MASK_ALL = 32'hFFFF_FFFF;

  typedef logic [15:0] teh_count_type;
endpackage : teh_pkg

// *** design/teh_input_cond.sv ***
`timescale 1ns/1ps
// one capture channel input: polarity, last level and edge strobes
module teh_input_cond
  import teh_pkg::*;
(
  input wire logic mclk,  // kernel clock
  input wire logic nrst,  // sync reset, active low
  input wire logic ce,  // clock enable, freezes state
  input wire logic raw,  // channel level, synchronous to mclk
  input wire logic invert,  // polarity bit
  output logic level,  // unfiltered, polarity applied
  output logic rise,  // one-cycle strobe on a rising level
  output logic fall  // one-cycle strobe on a falling level
);
  logic prev_q;  // level seen on the last enabled edge
  logic prev_d;

  // polarity flips the input before edge detection, reversing direction
  assign level = raw ^ invert;
  assign prev_d = level;
  assign rise = ce & level & ~prev_q;
  assign fall = ce & ~level & prev_q;

  // last level, held while clock enable is low
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      prev_q <= 1'b0;
    end else if (ce) begin
      prev_q <= prev_d;
    end
  end
endmodule : teh_input_cond

// *** design/teh_core.sv ***
`timescale 1ns/1ps
// How it works
// - encoder edges step counter with own direction
// - hardware alone sets direction while encoding
// - mode 001 a, 010 b, 011 both
// - encoder count wraps between zero and reload
// - a edges: rise down if b high
// - b edges: rise up if a high
// - both mode applies each table per input
// - source select 01 routes pin to channel
// - polarity bit inverts input, reversing direction
// - hall mode xors three pins into a
// - reset mode on a edge restarts counter
// - source 11 captures counter on trigger
// - channel 2 pulses internal trigger line
// - trigger rise commits preloaded output bits
// - half-word and word register accesses accepted
// - slave reset clears counter, raises update
// - slave reset sets trigger flag
module teh_core
  import teh_pkg::*;
(
  input wire logic mclk,  // kernel clock, 50 MHz
  input wire logic nrst,  // sync reset, active low
  input wire logic ce,  // clock enable
  input wire logic [7:0] bus_addr,  // byte address
  input wire logic [31:0] bus_wdata,  // write data
  input wire logic bus_wr,  // write strobe
  input wire logic bus_rd,  // read strobe
  input wire logic bus_word,  // 1 word, 0 half-word access
  output logic [31:0] bus_rdata,  // read data, cycle after strobe
  input wire logic chan1_in,  // channel 1 pin / hall 1
  input wire logic chan2_in,  // channel 2 pin / hall 2
  input wire logic chan3_in,  // hall 3
  input wire logic [3:0] internal_trigger_n,  // trigger lines from other timers
  output logic trig_pulse_out,  // channel 2 pulse for another timer
  output logic [7:0] out_ctl_active,  // active output-control bits
  output logic count_dir  // count_direction_flag
);
  // software registers
  logic [31:0] ctrl1_q, ctrl2_q, smctrl_q, ccmod_q, ccen_q, outctl_q;
  logic [31:0] ctrl1_d, ctrl2_d, smctrl_d, ccmod_d, ccen_d, outctl_d;
  teh_count_type cnt_q, cnt_d, ar_q, ar_d, ccdat1_q, ccdat1_d, ccdat2_q, ccdat2_d;
  logic [3:0] sts_q, sts_d;  // trigger, commutation, capture, update
  logic [7:0] act_q, act_d;  // active output-control set
  logic [3:0] itr_prev_q;  // last level of internal trigger lines
  logic [31:0] rdata_q, rdata_d;
  logic pulse_q, pulse_d;

  // bus decode
  wire [31:0] wmask = bus_word ? TEH_MASK_ALL : (bus_addr[1] ? TEH_MASK_HI : TEH_MASK_LO);
  wire [31:0] wdata_al = bus_word ? bus_wdata : {bus_wdata[15:0], bus_wdata[15:0]};
  wire wr_ctrl1 = bus_wr & (bus_addr[7:2] == TEH_OFF_CTRL1[7:2]);
  wire wr_ctrl2 = bus_wr & (bus_addr[7:2] == TEH_OFF_CTRL2[7:2]);
  wire wr_sm = bus_wr & (bus_addr[7:2] == TEH_OFF_SMCTRL[7:2]);
  wire wr_sts = bus_wr & (bus_addr[7:2] == TEH_OFF_STS[7:2]);
  wire wr_ccmod = bus_wr & (bus_addr[7:2] == TEH_OFF_CCMOD[7:2]);
  wire wr_ccen = bus_wr & (bus_addr[7:2] == TEH_OFF_CCEN[7:2]);
  wire wr_cnt = bus_wr & (bus_addr[7:2] == TEH_OFF_CNT[7:2]) & wmask[0];
  wire wr_ar = bus_wr & (bus_addr[7:2] == TEH_OFF_AR[7:2]) & wmask[0];
  wire wr_ccd2 = bus_wr & (bus_addr[7:2] == TEH_OFF_CCDAT2[7:2]) & wmask[0];
  wire wr_out = bus_wr & (bus_addr[7:2] == TEH_OFF_OUTCTL[7:2]);

  // half-word lanes merge into the old word
  function automatic logic [31:0] merge(input logic [31:0] old);
    merge = (old & ~wmask) | (wdata_al & wmask);
  endfunction : merge

  // field views
  wire run = ctrl1_q[TEH_B_RUN];
  wire uprs = ctrl1_q[TEH_B_UPRS];
  wire updis = ctrl1_q[TEH_B_UPDIS];
  wire dir_q = ctrl1_q[TEH_B_DIR];
  wire hall = ctrl2_q[TEH_B_HALL];
  wire ccr_preload_ctl = ctrl2_q[TEH_B_CCR_PRELOAD_CTL];
  wire ccr_update_select = ctrl2_q[TEH_B_CCR_UPDATE_SELECT];
  wire [2:0] slave_mode_select = smctrl_q[TEH_B_SLAVE_MODE_SELECT +: 3];
  wire [2:0] trigger_select = smctrl_q[TEH_B_TRIGGER_SELECT +: 3];
  wire [1:0] chan1_source_select = ccmod_q[TEH_B_CHAN1_SOURCE_SELECT +: 2];
  wire [1:0] chan2_source_select = ccmod_q[TEH_B_CHAN2_SOURCE_SELECT +: 2];

  // channel inputs; hall mode folds three pins into input_a
  wire input_a = hall ? (chan1_in ^ chan2_in ^ chan3_in) : chan1_in;
  logic fa, fa_rise, fa_fall, fb, fb_rise, fb_fall;

  teh_input_cond u_cond_a (
    .mclk(mclk),
    .nrst(nrst),
    .ce(ce),
    .raw(input_a),
    .invert(ccen_q[TEH_B_CHAN1_POLARITY]),
    .level(fa),
    .rise(fa_rise),
    .fall(fa_fall)
  );

  teh_input_cond u_cond_b (
    .mclk(mclk),
    .nrst(nrst),
    .ce(ce),
    .raw(chan2_in),
    .invert(ccen_q[TEH_B_CHAN2_POLARITY]),
    .level(fb),
    .rise(fb_rise),
    .fall(fb_fall)
  );

  // encoder only sees channels routed direct to their pins
  wire a_on = (chan1_source_select == TEH_CS_DIRECT);
  wire b_on = (chan2_source_select == TEH_CS_DIRECT);
  wire enc = (slave_mode_select == TEH_SM_ENC_A) | (slave_mode_select == TEH_SM_ENC_B) | (slave_mode_select == TEH_SM_ENC_AB);
  wire use_a = (slave_mode_select == TEH_SM_ENC_A) | (slave_mode_select == TEH_SM_ENC_AB);
  wire use_b = (slave_mode_select == TEH_SM_ENC_B) | (slave_mode_select == TEH_SM_ENC_AB);
  wire ea = use_a & a_on & (fa_rise | fa_fall);
  wire eb = use_b & b_on & (fb_rise | fb_fall);
  // a edge: rise counts down when b high; b edge: rise counts up when a high
  // a jitter with b steady alternates down/up, so bounce nets zero
  wire enc_down = ea ? (fa_rise ? fb : ~fb) : (fb_rise ? ~fa : fa);
  wire enc_step = run & (ea | eb);
  // outside encoder the counter runs on the kernel clock, software direction
  wire step = enc ? enc_step : run;
  wire down = enc ? enc_down : dir_q;

  // trigger input selection; every source is a one-cycle event
  wire [3:0] itr_rise = internal_trigger_n & ~itr_prev_q;
  logic trig_evt;
  always_comb begin
    case (trigger_select)
      TEH_TS_AEDGE: trig_evt = fa_rise | fa_fall;  // any hall change
      TEH_TS_FA: trig_evt = fa_rise;
      TEH_TS_FB: trig_evt = fb_rise;
      3'h7: trig_evt = 1'b0;
      default: trig_evt = ce & itr_rise[trigger_select[1:0]];
    endcase
  end

  wire slave_rst = ce & run & (slave_mode_select == TEH_SM_RESET) & trig_evt;
  wire cap1 = ce & (((chan1_source_select == TEH_CS_TRC) & trig_evt) | (a_on & fa_rise));
  wire com_evt = ce & ccr_preload_ctl & ccr_update_select & trig_evt;

  // wrap values for both directions
  wire teh_count_type inc_val = (cnt_q >= ar_q) ? 16'h0000 : 16'(cnt_q + 16'h0001);
  wire teh_count_type dec_val = (cnt_q == 16'h0000) ? ar_q : 16'(cnt_q - 16'h0001);
  wire wrap = step & (down ? (cnt_q == 16'h0000) : (cnt_q >= ar_q));
  wire upd_evt = ce & ~updis & (wrap | (slave_rst & ~uprs));

  // counter next state; slave reset beats software write
  always_comb begin
    cnt_d = cnt_q;
    if (slave_rst) begin
      cnt_d = 16'h0000;
    end else if (wr_cnt) begin
      cnt_d = wdata_al[15:0];
    end else if (step) begin
      cnt_d = down ? dec_val : inc_val;
    end
  end

  // control one: hardware owns the direction bit while encoding
  always_comb begin
    ctrl1_d = wr_ctrl1 ? merge(ctrl1_q) : ctrl1_q;
    if (enc) begin
      ctrl1_d[TEH_B_DIR] = enc_step ? enc_down : dir_q;
    end
  end

  // sticky flags: write 0 clears, a same-cycle set wins
  wire [3:0] sts_clr = wr_sts ? {~wdata_al[TEH_B_TRGF] & wmask[TEH_B_TRGF],
                                 ~wdata_al[TEH_B_COMF] & wmask[TEH_B_COMF],
                                 ~wdata_al[TEH_B_CC1F] & wmask[TEH_B_CC1F],
                                 ~wdata_al[TEH_B_UDF] & wmask[TEH_B_UDF]} : 4'h0;
  wire [3:0] sts_set = {slave_rst, com_evt, cap1, upd_evt};
  assign sts_d = (sts_q & ~sts_clr) | sts_set;

  // plain registers
  assign ctrl2_d = wr_ctrl2 ? merge(ctrl2_q) : ctrl2_q;
  assign smctrl_d = wr_sm ? merge(smctrl_q) : smctrl_q;
  assign ccmod_d = wr_ccmod ? merge(ccmod_q) : ccmod_q;
  assign ccen_d = wr_ccen ? merge(ccen_q) : ccen_q;
  assign outctl_d = wr_out ? merge(outctl_q) : outctl_q;
  assign ar_d = wr_ar ? wdata_al[15:0] : ar_q;
  assign ccdat2_d = wr_ccd2 ? wdata_al[15:0] : ccdat2_q;
  assign ccdat1_d = cap1 ? cnt_q : ccdat1_q;
  // without preload the active set follows software at once
  assign act_d = com_evt ? outctl_q[7:0] : (ccr_preload_ctl ? act_q : outctl_q[7:0]);
  // channel 2 in output mode pulses on compare match
  assign pulse_d = ce & step & (chan2_source_select == TEH_CS_OUT) & (cnt_q == ccdat2_q);

  // read mux; unmapped words read zero, half reads come in the low lane
  logic [31:0] rword;
  always_comb begin
    case (bus_addr[7:2])
      TEH_OFF_CTRL1[7:2]: rword = ctrl1_q;
      TEH_OFF_CTRL2[7:2]: rword = ctrl2_q;
      TEH_OFF_SMCTRL[7:2]: rword = smctrl_q;
      TEH_OFF_STS[7:2]: rword = {25'h0, sts_q[3], sts_q[2], 3'h0, sts_q[1], sts_q[0]};
      TEH_OFF_CCMOD[7:2]: rword = ccmod_q;
      TEH_OFF_CCEN[7:2]: rword = ccen_q;
      TEH_OFF_CNT[7:2]: rword = {16'h0000, cnt_q};
      TEH_OFF_AR[7:2]: rword = {16'h0000, ar_q};
      TEH_OFF_CCDAT1[7:2]: rword = {16'h0000, ccdat1_q};
      TEH_OFF_CCDAT2[7:2]: rword = {16'h0000, ccdat2_q};
      TEH_OFF_OUTCTL[7:2]: rword = {16'h0000, act_q, outctl_q[7:0]};
      default: rword = 32'h0000_0000;
    endcase
  end
  assign rdata_d = bus_rd ? ((!bus_word && bus_addr[1]) ? {16'h0000, rword[31:16]} : rword)
                          : 32'h0000_0000;

  // state update, frozen while clock enable is low
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ctrl1_q <= TEH_RST_WORD;
      ctrl2_q <= TEH_RST_WORD;
      smctrl_q <= TEH_RST_WORD;
      ccmod_q <= TEH_RST_WORD;
      ccen_q <= TEH_RST_WORD;
      outctl_q <= TEH_RST_WORD;
      sts_q <= 4'h0;
      cnt_q <= 16'h0000;
      ar_q <= TEH_RST_AR;
      ccdat1_q <= 16'h0000;
      ccdat2_q <= 16'h0000;
      act_q <= 8'h00;
      itr_prev_q <= 4'h0;
      pulse_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else if (ce) begin
      ctrl1_q <= ctrl1_d;
      ctrl2_q <= ctrl2_d;
      smctrl_q <= smctrl_d;
      ccmod_q <= ccmod_d;
      ccen_q <= ccen_d;
      outctl_q <= outctl_d;
      sts_q <= sts_d;
      cnt_q <= cnt_d;
      ar_q <= ar_d;
      ccdat1_q <= ccdat1_d;
      ccdat2_q <= ccdat2_d;
      act_q <= act_d;
      itr_prev_q <= internal_trigger_n;
      pulse_q <= pulse_d;
      rdata_q <= rdata_d;
    end
  end

  assign bus_rdata = rdata_q;
  assign trig_pulse_out = pulse_q;
  assign out_ctl_active = act_q;
  assign count_dir = dir_q;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  wire quiet = ce & ~slave_rst & ~wr_cnt & ~wr_ctrl1;
  sequence s_a_edge_b_high;
    quiet & run & (slave_mode_select == TEH_SM_ENC_A) & a_on & fa_rise & fb;
  endsequence
  sequence s_b_rise_a_high;
    quiet & run & (slave_mode_select == TEH_SM_ENC_B) & b_on & fb_rise & fa;
  endsequence

  a_a_rise_down: assert property (s_a_edge_b_high |=> cnt_q == $past(dec_val) && dir_q)
    else $error("input_a rise with input_b high did not count down");
  a_b_rise_up: assert property (s_b_rise_a_high |=> cnt_q == $past(inc_val) && !dir_q)
    else $error("input_b rise with input_a high did not count up");
  a_both_b_fall: assert property (quiet & run & (slave_mode_select == TEH_SM_ENC_AB) & b_on & fb_fall
      & fa & ~ea |=> cnt_q == $past(dec_val))
    else $error("both-edge input_b fall did not count down");
  a_enc_range: assert property (quiet & enc & (cnt_q <= ar_q) & ~wr_ar |=> cnt_q <= ar_q)
    else $error("encoder count left the reload range");
  a_stop_hold: assert property (quiet & enc & ~run |=> $stable(cnt_q) && $stable(dir_q))
    else $error("stopped encoder changed count or direction");
  a_hall_restart: assert property (slave_rst ##0 (!wr_sts) |=> cnt_q == 16'h0000
      && sts_q[3])
    else $error("slave reset did not restart counter and set flag");
  a_trc_capture: assert property (ce & (chan1_source_select == TEH_CS_TRC) & trig_evt
      |=> ccdat1_q == $past(cnt_q))
    else $error("trigger capture missed counter value");
  a_com_commit: assert property (com_evt |=> out_ctl_active == $past(outctl_q[7:0]))
    else $error("commutation did not load active output bits");
  a_ch2_pulse: assert property (trig_pulse_out |-> $past(cnt_q) == ccdat2_q
      || $past(wr_ccd2))
    else $error("channel 2 pulse without compare match");
endmodule : teh_core

// *** tb/teh_sensor_model.sv ***
`timescale 1ns/1ps
// motor side: quadrature encoder on pins a/b, third hall sensor on pin c
module teh_sensor_model (
  input wire logic mclk,  // kernel clock, pins move just after its edge
  output logic pin_a,  // encoder a / hall 1
  output logic pin_b,  // encoder b / hall 2
  output logic pin_c  // hall 3
);
  int phase;  // gray position 0..3: ab = 00, 10, 11, 01

  // sensors idle low until the shaft moves
  initial begin
    phase = 0;
    pin_a = 1'b0;
    pin_b = 1'b0;
    pin_c = 1'b0;
  end

  // positive steps turn forward with a leading a, negative turn back
  task automatic quad(input int steps);
    repeat (steps < 0 ? -steps : steps) begin
      phase = (phase + (steps < 0 ? 3 : 1)) % 4;
      @(posedge mclk);
      pin_a <= (phase == 1) || (phase == 2);
      pin_b <= (phase >= 2);
      // spacing leaves room for the one-cycle count latency
      repeat (3) @(posedge mclk);
    end
  endtask : quad

  // shaft rocking on one edge: a bounces while b rests
  task automatic jitter(input int n);
    repeat (n) begin
      @(posedge mclk);
      pin_a <= ~pin_a;
      repeat (3) @(posedge mclk);
    end
  endtask : jitter

  // one commutation step seen by the third sensor
  task automatic hall;
    @(posedge mclk);
    pin_c <= ~pin_c;
    repeat (3) @(posedge mclk);
  endtask : hall
endmodule : teh_sensor_model

// *** tb/teh_core_bench.sv ***
`timescale 1ns/1ps
// one compare: counted, and a mismatch reported at once
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin n_errors++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end

module teh_core_bench
  import teh_pkg::*;
;
  logic mclk, nrst, ce, bus_wr, bus_rd, bus_word;  // clock, reset, bus strobes
  logic [7:0] bus_addr;  // byte address
  logic [31:0] bus_wdata, bus_rdata, rv;  // bus data, last read value
  logic chan1_in, chan2_in, chan3_in;  // sensor pins
  logic [3:0] internal_trigger_n;  // lines from a neighbour timer
  logic trig_pulse_out, count_dir;  // pulse to neighbour, direction
  logic [7:0] out_ctl_active;  // committed output-control bits
  logic found;  // pulse seen flag
  int n_errors, n_compared;  // tally
  logic [2:0] modes [3] = '{TEH_SM_ENC_A, TEH_SM_ENC_B, TEH_SM_ENC_AB};
  int per [3] = '{2, 2, 4};  // counts per full quadrature cycle

  teh_core DUT (.mclk(mclk), .nrst(nrst), .ce(ce), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_word(bus_word),
    .bus_rdata(bus_rdata), .chan1_in(chan1_in), .chan2_in(chan2_in),
    .chan3_in(chan3_in), .internal_trigger_n(internal_trigger_n),
    .trig_pulse_out(trig_pulse_out), .out_ctl_active(out_ctl_active),
    .count_dir(count_dir));
  teh_sensor_model snsr (.mclk(mclk), .pin_a(chan1_in), .pin_b(chan2_in),
    .pin_c(chan3_in));

  // 50 MHz kernel clock
  initial mclk = 1'b0;
  always #10 mclk = ~mclk;

  // one-cycle write strobe; w low selects a half-word access
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic w = 1'b1);
    @(posedge mclk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    bus_word <= w;
    @(posedge mclk);
    bus_wr <= 1'b0;
  endtask : wr

  // data stands only in the cycle after the strobe, so sample it there
  task automatic rd(input logic [7:0] a, input logic w = 1'b1);
    @(posedge mclk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    bus_word <= w;
    @(posedge mclk);
    bus_rd <= 1'b0;
    #1 rv = bus_rdata;
  endtask : rd

  task automatic chk_rd(input string nm, input logic [7:0] a, input logic [31:0] ex,
                        input logic w = 1'b1);
    rd(a, w);
    `CHK(nm, ex, rv)
  endtask : chk_rd

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_word = 1'b1;
    bus_addr = 8'h00;
    bus_wdata = 32'h0;
    internal_trigger_n = 4'h0;
    n_errors = 0;
    n_compared = 0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    // reset values, unmapped and read-only places, half accesses
    chk_rd("ar_reset", TEH_OFF_AR, 32'h0000_FFFF);
    chk_rd("ctrl1_reset", TEH_OFF_CTRL1, TEH_RST_WORD);
    wr(8'hFC, 32'hFFFF_FFFF);
    chk_rd("unmapped", 8'hFC, 32'h0);
    wr(TEH_OFF_CCDAT1, 32'h1234);
    chk_rd("capture_ro", TEH_OFF_CCDAT1, 32'h0);
    wr(TEH_OFF_AR, 32'h9, 1'b0);
    chk_rd("ar_low_half", TEH_OFF_AR, 32'h9, 1'b0);
    chk_rd("ar_high_half", TEH_OFF_AR + 8'h02, 32'h0, 1'b0);
    // both pins routed straight in for the encoder modes
    wr(TEH_OFF_CCMOD, 32'h0000_0101);
    // each encoder variant: one cycle forward, two back across zero
    for (int i = 0; i < 3; i++) begin
      wr(TEH_OFF_SMCTRL, {29'h0, modes[i]});
      wr(TEH_OFF_CNT, 32'h0);
      wr(TEH_OFF_CTRL1, 32'h1);
      snsr.quad(4);
      chk_rd("enc_fwd", TEH_OFF_CNT, 32'(per[i]));
      `CHK("dir_up", 1'b0, count_dir)
      snsr.quad(-8);
      chk_rd("enc_back", TEH_OFF_CNT, 32'(10 - per[i]));
      `CHK("dir_down", 1'b1, count_dir)
      wr(TEH_OFF_CTRL1, 32'h0);
    end
    // inverted a turns forward motion into down counts
    wr(TEH_OFF_CCEN, 32'h2);
    wr(TEH_OFF_CNT, 32'h0);
    wr(TEH_OFF_CTRL1, 32'h1);
    snsr.quad(4);
    chk_rd("inv_count", TEH_OFF_CNT, 32'h6);
    `CHK("inv_dir", 1'b1, count_dir)
    // polarity restored while stopped, else the level flip would count
    wr(TEH_OFF_CTRL1, 32'h0);
    wr(TEH_OFF_CCEN, 32'h0);
    wr(TEH_OFF_CNT, 32'h0);
    wr(TEH_OFF_CTRL1, 32'h1);
    snsr.jitter(6);
    chk_rd("jitter_net", TEH_OFF_CNT, 32'h0);
    // stopped counter ignores motion
    wr(TEH_OFF_CTRL1, 32'h0);
    wr(TEH_OFF_CNT, 32'h0);
    snsr.quad(-4);
    chk_rd("stop_count", TEH_OFF_CNT, 32'h0);
    `CHK("stop_dir", 1'b1, count_dir)
    // commutation: preloaded bits wait for a rising trigger line
    wr(TEH_OFF_SMCTRL, 32'h0);
    wr(TEH_OFF_CTRL2, 32'h5);
    wr(TEH_OFF_OUTCTL, 32'hA5);
    `CHK("act_held", 8'h00, out_ctl_active)
    @(posedge mclk) internal_trigger_n <= 4'h1;
    repeat (4) @(posedge mclk);
    #1 `CHK("act_loaded", 8'hA5, out_ctl_active)
    rd(TEH_OFF_STS);
    `CHK("com_flag", 1'b1, rv[TEH_B_COMF])
    @(posedge mclk) internal_trigger_n <= 4'h0;
    // channel 2 compare pulse for the neighbour timer, bounded wait
    wr(TEH_OFF_CTRL2, 32'h0);
    wr(TEH_OFF_CCMOD, 32'h0);
    wr(TEH_OFF_CCDAT2, 32'h5);
    wr(TEH_OFF_CNT, 32'h0);
    wr(TEH_OFF_CTRL1, 32'h1);
    found = 1'b0;
    for (int k = 0; k < 40 && !found; k++) begin
      @(posedge mclk);
      #1 if (trig_pulse_out === 1'b1) found = 1'b1;
    end
    `CHK("ch2_pulse", 1'b1, found)
    if (found !== 1'b1) tally_and_finish;
    wr(TEH_OFF_CTRL1, 32'h0);
    // hall: xor of three pins, reset mode on any edge, capture on trigger
    wr(TEH_OFF_AR, 32'hFFFF);
    wr(TEH_OFF_CCMOD, 32'h3);
    wr(TEH_OFF_CTRL2, 32'h80);
    wr(TEH_OFF_SMCTRL, 32'h44);
    wr(TEH_OFF_STS, 32'h0);
    wr(TEH_OFF_CNT, 32'h0);
    wr(TEH_OFF_CTRL1, 32'h1);
    repeat (20) @(posedge mclk);
    snsr.hall();
    rd(TEH_OFF_STS);
    `CHK("hall_flags", 32'h43, rv & 32'h43)
    rd(TEH_OFF_CCDAT1);
    `CHK("hall_interval", 1'b1, rv >= 32'd20)
    rd(TEH_OFF_CNT);
    `CHK("hall_restart", 1'b1, rv < 32'd16)
    tally_and_finish;
  end
endmodule : teh_core_bench
